// *** core/burst_fault_consts.svh ***
// Register map, field positions, reset values and timing for the burst fault monitor.
// Assumes a 40 MHz ref_clk and 32-bit APB data.
`ifndef BURST_FAULT_MONITOR_CONSTS_SVH
`define BURST_FAULT_MONITOR_CONSTS_SVH

`define OFS_CTRL 8'h00
`define OFS_PULSE_CFG 8'h04
`define OFS_STATUS 8'h08
`define OFS_IRQ_STAT 8'h0c
`define OFS_IRQ_MASK 8'h10

`define CTRL_MODE_LSB 0
`define CTRL_SINGLE_COIL 2
`define CTRL_ILIM_LSB 4
`define CTRL_TMO_LSB 8
`define CTRL_CMD_ENABLE 12
`define CTRL_CMD_END 13
`define CTRL_LOW_POWER 16

`define ST_PULSE_FAULT 0
`define ST_STUCK_FAULT 1
`define ST_ACTIVE 4
`define ST_CNT_LSB 8
`define ST_STATE_LSB 16

`define IRQ_PULSE_FAULT 0
`define IRQ_STUCK_FAULT 1
`define IRQ_BURST_END 2

`define TMO_SEL_OFF 3'h7
`define PULSE_NUM_RST 8'h0a
`define ILIM_RST 3'h0
`define TMO_SEL_RST 3'h3
`define CLK_PERIOD_NS 25
`define STUCK_STEP_NS 1000

`endif

// *** core/burst_fault_pkg.sv ***
// Types shared by the burst fault monitor and its helpers.
// Assumes the constants header is included where numbers are needed.
package burst_fault_pkg;

	typedef enum logic [1:0] {
		MODE_SPI_TRIG = 2'h0,
		MODE_FIRST_EN = 2'h1,
		MODE_BOTH_PINS = 2'h2,
		MODE_SECOND_ONLY = 2'h3
	} io_mode_t;

	typedef enum logic [3:0] {
		BST_IDLE = 4'h1,
		BST_ARMED = 4'h2,
		BST_ACTIVE = 4'h4,
		BST_BLANK = 4'h8
	} burst_state_t;

	typedef struct packed {
		logic first;
		logic second;
	} ctrl_pins_t;

	typedef struct packed {
		burst_state_t st;
		io_mode_t io_mode;
		logic single_coil_drive_sel;
		logic [2:0] drive_current_limit_sel;
		logic [2:0] stuck_timeout_sel;
		logic low_power;
		logic [7:0] pulse_num;
		logic [7:0] pulse_cnt;
		logic pulse_count_fault;
		logic drive_stuck_fault;
		logic [2:0] irq_stat;
		logic [2:0] irq_mask;
		logic [31:0] rdata;
		logic phase_a_driver;
		logic phase_b_driver;
		ctrl_pins_t pins_prev;
	} mon_state_t;

endpackage : burst_fault_pkg

// *** core/pin_sync.sv ***
// Two-flop synchroniser for the asynchronous control pins.
// Assumes inputs may change at any time relative to ref_clk.
`timescale 1ns/10ps
module pin_sync #(
	parameter int WIDTH = 2
) (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_reg;

	// The first stage feeds only the second stage
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			// Reset to the pulled-up idle level so release shows no false edge
			meta_reg <= '1;
			sync_out <= '1;
		end else begin
			meta_reg <= async_in;
			sync_out <= meta_reg;
		end
	end
endmodule : pin_sync

// *** core/stuck_timer.sv ***
// Restartable timeout counter used for the stuck check and the blank-out interval.
// Assumes restart and run come from logic on ref_clk.
`timescale 1ns/10ps
module stuck_timer #(
	parameter int CW = 16
) (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic run,
	input wire logic restart,
	input wire logic [CW-1:0] limit,
	output logic expired
);
	logic [CW-1:0] cnt_reg;
	logic [CW-1:0] cnt_next;

	always_comb begin
		expired = 1'b0;
		cnt_next = cnt_reg;
		if (restart || !run) begin
			cnt_next = '0;
		end else if (cnt_reg >= limit - CW'(1)) begin
			expired = 1'b1;
			cnt_next = '0;
		end else begin
			cnt_next = cnt_reg + CW'(1);
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			cnt_reg <= '0;
		end else begin
			cnt_reg <= cnt_next;
		end
	end
endmodule : stuck_timer

// *** core/burst_fault_monitor.sv ***
// Burst generator supervision: pulse-count check, stuck-drive timeout, driver phasing.
// Assumes an APB master on ref_clk and control pins that are asynchronous to it.
//
// Contract
// - In modes 0, 1 and 3 the pulse-count check arms at burst start, not at burst enable.
// - An end of burst from SPI or the first pin before the pulse count is reached sets the pulse-count fault.
// - After burst start a qualifying pin toggle must come within the stuck timeout or the stuck check trips.
// - A stuck trip forces end of burst at once so neither low-side driver stays on.
// - A stuck trip sets the drive-stuck fault flag, readable by software.
// - In modes 0, 1 and 3 a stuck-forced end before the pulse count is reached also sets the pulse-count fault.
// - The drive-stuck fault clears on a new burst start, on writing 0x7 to the timeout field, or on low-power entry.
// - The pulse-count fault clears only on a new burst start or on low-power entry.
// - With single-coil drive cleared the two low-side drivers switch in opposite phase in modes 0, 1 and 3; in mode 2 each follows its own pin.
// - With single-coil drive set both low-side drivers switch in phase.
// - The selected current limit applies unchanged in single-coil and centre-tap drive.
// - Pulses are counted falling edge to falling edge on the second pin from burst start.
// - In mode 3 a blank-out interval of the stuck timeout follows end of burst and blocks a new start.
// - In mode 2 the pulse count is ignored and no pulse-count check applies.
`timescale 1ns/10ps
`include "burst_fault_consts.svh"
module burst_fault_monitor
	import burst_fault_pkg::*;
#(
	parameter int TCW = 16
) (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic ctrl_pin_first,
	input wire logic ctrl_pin_second,
	output logic phase_a_driver,
	output logic phase_b_driver,
	output logic [2:0] drive_current_limit_sel,
	output logic pulse_count_fault,
	output logic drive_stuck_fault,
	output logic irq
);
	// One timeout step, rounded up to whole cycles
	localparam int STEP_CYC = (`STUCK_STEP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;

	mon_state_t s_reg;
	mon_state_t s_next;
	ctrl_pins_t pins_sync;
	logic timer_run;
	logic timer_restart;
	logic timer_expired;
	logic [TCW-1:0] timer_limit;

	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic fell(input logic prev, input logic cur);
		fell = prev & ~cur;
	endfunction : fell

	function automatic logic [TCW-1:0] tmo_cycles(input logic [2:0] sel);
		tmo_cycles = TCW'((int'(sel) + 1) * STEP_CYC);
	endfunction : tmo_cycles

	function automatic logic is_reg(input logic [7:0] a);
		is_reg = (a == `OFS_CTRL) || (a == `OFS_PULSE_CFG) || (a == `OFS_STATUS) ||
			(a == `OFS_IRQ_STAT) || (a == `OFS_IRQ_MASK);
	endfunction : is_reg

	// ****************************************
	// Pin synchroniser and timeout counter
	// ****************************************
	pin_sync #(
		.WIDTH(2)
	) u_pin_sync (
		.ref_clk(ref_clk),
		.nrst(nrst),
		.async_in({ctrl_pin_first, ctrl_pin_second}),
		.sync_out(pins_sync)
	);

	stuck_timer #(
		.CW(TCW)
	) u_stuck_timer (
		.ref_clk(ref_clk),
		.nrst(nrst),
		.run(timer_run),
		.restart(timer_restart),
		.limit(timer_limit),
		.expired(timer_expired)
	);

	// ****************************************
	// Next-state logic
	// ****************************************
	logic wr_acc;
	logic rd_acc;
	logic setup;
	logic cmd_enable;
	logic cmd_end;
	logic first_fell;
	logic first_rose;
	logic second_fell;
	logic toggle;
	logic start_burst;
	logic end_burst;
	logic early_end;
	logic stuck_trip;
	logic cnt_done;
	logic count_checked;
	logic set_pulse_fault;
	logic set_stuck_fault;
	logic lp_entry;
	logic tmo_off_wr;
	logic [2:0] irq_set;

	always_comb begin
		s_next = s_reg;
		setup = psel && !penable;
		wr_acc = psel && penable && pwrite && is_reg(paddr);
		rd_acc = psel && penable && !pwrite && is_reg(paddr);
		cmd_enable = wr_acc && (paddr == `OFS_CTRL) && pwdata[`CTRL_CMD_ENABLE];
		cmd_end = wr_acc && (paddr == `OFS_CTRL) && pwdata[`CTRL_CMD_END];
		first_fell = fell(s_reg.pins_prev.first, pins_sync.first);
		first_rose = fell(pins_sync.first, s_reg.pins_prev.first);
		second_fell = fell(s_reg.pins_prev.second, pins_sync.second);
		// Mode 2 watches both pins, the other modes only the clock pin
		if (s_reg.io_mode == MODE_BOTH_PINS) begin
			toggle = (s_reg.pins_prev != pins_sync);
		end else begin
			toggle = (s_reg.pins_prev.second != pins_sync.second);
		end
		count_checked = (s_reg.io_mode != MODE_BOTH_PINS);
		// Count 0 means continuous in modes 0 and 1; mode 3 has no continuous bursting
		if (s_reg.io_mode == MODE_SECOND_ONLY) begin
			cnt_done = (s_reg.pulse_cnt >= s_reg.pulse_num) && (s_reg.pulse_cnt != 8'h00);
		end else begin
			cnt_done = (s_reg.pulse_num != 8'h00) && (s_reg.pulse_cnt >= s_reg.pulse_num);
		end
		stuck_trip = (s_reg.st == BST_ACTIVE) && timer_expired &&
			(s_reg.stuck_timeout_sel != `TMO_SEL_OFF);
		start_burst = 1'b0;
		end_burst = 1'b0;
		early_end = 1'b0;
		lp_entry = 1'b0;
		tmo_off_wr = 1'b0;
		s_next.pins_prev = pins_sync;

		// ****************************************
		// Burst sequencing
		// ****************************************
		unique case (s_reg.st)
			BST_IDLE: begin
				unique case (s_reg.io_mode)
					MODE_SPI_TRIG: if (cmd_enable) s_next.st = BST_ARMED;
					MODE_FIRST_EN: if (first_fell) s_next.st = BST_ARMED;
					MODE_BOTH_PINS: if (first_fell || second_fell) s_next.st = BST_ARMED;
					MODE_SECOND_ONLY: if (second_fell) start_burst = 1'b1;
				endcase
			end
			BST_ARMED: begin
				if ((s_reg.io_mode == MODE_SPI_TRIG && cmd_end) ||
					(s_reg.io_mode == MODE_FIRST_EN && first_rose)) begin
					s_next.st = BST_IDLE;
				end else if (s_reg.io_mode == MODE_BOTH_PINS) begin
					start_burst = first_fell;
				end else begin
					start_burst = second_fell;
				end
			end
			BST_ACTIVE: begin
				if (stuck_trip) begin
					end_burst = 1'b1;
					early_end = !cnt_done || (s_reg.pulse_num == 8'h00);
				end else if (count_checked && cnt_done) begin
					end_burst = 1'b1;
				end else if (s_reg.io_mode == MODE_SPI_TRIG && cmd_end) begin
					end_burst = 1'b1;
					early_end = (s_reg.pulse_num != 8'h00);
				end else if (s_reg.io_mode == MODE_FIRST_EN && first_rose) begin
					end_burst = 1'b1;
					early_end = (s_reg.pulse_num != 8'h00);
				end else if (s_reg.io_mode == MODE_BOTH_PINS && pins_sync.first &&
					pins_sync.second) begin
					end_burst = 1'b1;
				end
				if (second_fell) begin
					s_next.pulse_cnt = s_reg.pulse_cnt + 8'h01;
				end
				if (end_burst) begin
					s_next.st = (s_reg.io_mode == MODE_SECOND_ONLY) ? BST_BLANK : BST_IDLE;
				end
			end
			BST_BLANK: begin
				// Pin edges are ignored here so a still-running clock cannot retrigger
				if (timer_expired) s_next.st = BST_IDLE;
			end
			default: s_next.st = BST_IDLE;
		endcase
		if (start_burst) begin
			s_next.st = BST_ACTIVE;
			s_next.pulse_cnt = 8'h00;
		end

		// ****************************************
		// Register writes
		// ****************************************
		if (wr_acc && paddr == `OFS_CTRL) begin
			s_next.io_mode = io_mode_t'(pwdata[`CTRL_MODE_LSB +: 2]);
			s_next.single_coil_drive_sel = pwdata[`CTRL_SINGLE_COIL];
			s_next.drive_current_limit_sel = pwdata[`CTRL_ILIM_LSB +: 3];
			s_next.stuck_timeout_sel = pwdata[`CTRL_TMO_LSB +: 3];
			s_next.low_power = pwdata[`CTRL_LOW_POWER];
			lp_entry = pwdata[`CTRL_LOW_POWER] && !s_reg.low_power;
			tmo_off_wr = (pwdata[`CTRL_TMO_LSB +: 3] == `TMO_SEL_OFF);
		end
		if (wr_acc && paddr == `OFS_PULSE_CFG) begin
			s_next.pulse_num = pwdata[7:0];
		end
		if (wr_acc && paddr == `OFS_IRQ_MASK) begin
			s_next.irq_mask = pwdata[2:0];
		end
		// Low power stops any burst and keeps the sequencer idle
		if (s_next.low_power) begin
			s_next.st = BST_IDLE;
			start_burst = 1'b0;
			end_burst = end_burst || (s_reg.st == BST_ACTIVE);
		end

		// ****************************************
		// Fault flags: a set in the clearing cycle wins
		// ****************************************
		set_pulse_fault = early_end && count_checked;
		set_stuck_fault = stuck_trip;
		if (start_burst || lp_entry) begin
			s_next.pulse_count_fault = 1'b0;
		end
		if (start_burst || lp_entry || tmo_off_wr) begin
			s_next.drive_stuck_fault = 1'b0;
		end
		if (set_pulse_fault) s_next.pulse_count_fault = 1'b1;
		if (set_stuck_fault) s_next.drive_stuck_fault = 1'b1;

		// ****************************************
		// Interrupt status, cleared by reading it
		// ****************************************
		irq_set = 3'h0;
		irq_set[`IRQ_PULSE_FAULT] = set_pulse_fault;
		irq_set[`IRQ_STUCK_FAULT] = set_stuck_fault;
		irq_set[`IRQ_BURST_END] = end_burst;
		if (rd_acc && paddr == `OFS_IRQ_STAT) begin
			// Clear only what the read returned, so an event during setup is kept
			s_next.irq_stat = (s_reg.irq_stat & ~s_reg.rdata[2:0]) | irq_set;
		end else begin
			s_next.irq_stat = s_reg.irq_stat | irq_set;
		end

		// ****************************************
		// Drivers follow the pins only while bursting
		// ****************************************
		if (s_next.st == BST_ACTIVE) begin
			if (s_reg.io_mode == MODE_BOTH_PINS) begin
				s_next.phase_a_driver = ~pins_sync.first;
				s_next.phase_b_driver = s_reg.single_coil_drive_sel ? ~pins_sync.first :
					~pins_sync.second;
			end else begin
				s_next.phase_a_driver = ~pins_sync.second;
				s_next.phase_b_driver = s_reg.single_coil_drive_sel ? ~pins_sync.second :
					pins_sync.second;
			end
		end else begin
			// Both FETs off outside a burst, including after a forced end
			s_next.phase_a_driver = 1'b0;
			s_next.phase_b_driver = 1'b0;
		end

		// ****************************************
		// Read data is captured in the setup cycle
		// ****************************************
		s_next.rdata = 32'h0;
		if (setup && !pwrite) begin
			unique case (paddr)
				`OFS_CTRL: begin
					s_next.rdata[`CTRL_MODE_LSB +: 2] = s_reg.io_mode;
					s_next.rdata[`CTRL_SINGLE_COIL] = s_reg.single_coil_drive_sel;
					s_next.rdata[`CTRL_ILIM_LSB +: 3] = s_reg.drive_current_limit_sel;
					s_next.rdata[`CTRL_TMO_LSB +: 3] = s_reg.stuck_timeout_sel;
					s_next.rdata[`CTRL_LOW_POWER] = s_reg.low_power;
				end
				`OFS_PULSE_CFG: s_next.rdata[7:0] = s_reg.pulse_num;
				`OFS_STATUS: begin
					s_next.rdata[`ST_PULSE_FAULT] = s_reg.pulse_count_fault;
					s_next.rdata[`ST_STUCK_FAULT] = s_reg.drive_stuck_fault;
					s_next.rdata[`ST_ACTIVE] = (s_reg.st == BST_ACTIVE);
					s_next.rdata[`ST_CNT_LSB +: 8] = s_reg.pulse_cnt;
					s_next.rdata[`ST_STATE_LSB +: 4] = s_reg.st;
				end
				`OFS_IRQ_STAT: s_next.rdata[2:0] = s_reg.irq_stat;
				`OFS_IRQ_MASK: s_next.rdata[2:0] = s_reg.irq_mask;
				default: s_next.rdata = 32'h0;
			endcase
		end
	end

	// Timer serves the stuck check while active and the blank-out afterwards;
	// a mode-3 count end restarts it so the blank-out runs its full length
	always_comb begin
		timer_run = (s_reg.st == BST_ACTIVE) || (s_reg.st == BST_BLANK);
		timer_restart = (s_reg.st == BST_ACTIVE) && (toggle ||
			((s_reg.io_mode == MODE_SECOND_ONLY) && cnt_done));
		timer_limit = tmo_cycles(s_reg.stuck_timeout_sel);
	end

	// ****************************************
	// State register
	// ****************************************
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			s_reg.st <= BST_IDLE;
			s_reg.io_mode <= MODE_SPI_TRIG;
			s_reg.single_coil_drive_sel <= 1'b0;
			s_reg.drive_current_limit_sel <= `ILIM_RST;
			s_reg.stuck_timeout_sel <= `TMO_SEL_RST;
			s_reg.low_power <= 1'b0;
			s_reg.pulse_num <= `PULSE_NUM_RST;
			s_reg.pulse_cnt <= 8'h00;
			s_reg.pulse_count_fault <= 1'b0;
			s_reg.drive_stuck_fault <= 1'b0;
			s_reg.irq_stat <= 3'h0;
			s_reg.irq_mask <= 3'h0;
			s_reg.rdata <= 32'h0;
			s_reg.phase_a_driver <= 1'b0;
			s_reg.phase_b_driver <= 1'b0;
			s_reg.pins_prev <= '1;
		end else begin
			s_reg <= s_next;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	always_comb begin
		// Slave answers in the first access cycle, never stretches
		pready = 1'b1;
		pslverr = psel && penable && !is_reg(paddr);
		prdata = s_reg.rdata;
		phase_a_driver = s_reg.phase_a_driver;
		phase_b_driver = s_reg.phase_b_driver;
		// Same limit code in either coil mode, so the effective limit does not change
		drive_current_limit_sel = s_reg.drive_current_limit_sel;
		pulse_count_fault = s_reg.pulse_count_fault;
		drive_stuck_fault = s_reg.drive_stuck_fault;
		irq = |(s_reg.irq_stat & s_reg.irq_mask);
	end
endmodule : burst_fault_monitor

// *** tb/burst_fault_monitor_props.sv ***
// Concurrent checks on the ports of the burst fault monitor.
// Assumes a bind from the bench top and CTRL at byte address 0.
`timescale 1ns/10ps
module burst_fault_monitor_props (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic ctrl_pin_second,
	input wire logic phase_a_driver,
	input wire logic phase_b_driver,
	input wire logic [2:0] drive_current_limit_sel,
	input wire logic pulse_count_fault,
	input wire logic drive_stuck_fault
);
	// ********
	// Shadow of the control fields
	// ********
	logic ctrl_wr;
	logic drv_on;
	logic [1:0] mode_sh;
	logic coil_sh;
	logic [2:0] tmo_sh;
	logic [9:0] idle_cnt;
	int lim;
	assign ctrl_wr = psel && penable && pwrite && paddr == 8'h00;
	assign drv_on = phase_a_driver || phase_b_driver;
	assign lim = (int'(tmo_sh) + 1) * 40;
	// Raw pin is seen before the synchroniser, so bounds carry a few cycles of slack
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			mode_sh <= 2'h0;
			coil_sh <= 1'b0;
			tmo_sh <= 3'h3;
			idle_cnt <= 10'h000;
		end else begin
			if (ctrl_wr) begin
				mode_sh <= pwdata[1:0];
				coil_sh <= pwdata[2];
				tmo_sh <= pwdata[10:8];
			end
			if (!drv_on || $changed(ctrl_pin_second)) begin
				idle_cnt <= 10'h000;
			end else if (idle_cnt != 10'h3ff) begin
				idle_cnt <= idle_cnt + 10'h001;
			end
		end
	end
	// ********
	// Properties
	// ********
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	property p_ilim_copy;
		ctrl_wr |=> drive_current_limit_sel == $past(pwdata[6:4]);
	endproperty
	a_ilim_copy: assert property (p_ilim_copy) else $error("current limit not applied");
	property p_out_of_phase;
		(!coil_sh && mode_sh != 2'h2) |-> !(phase_a_driver && phase_b_driver);
	endproperty
	a_out_of_phase: assert property (p_out_of_phase) else $error("drivers on together");
	property p_in_phase;
		(coil_sh && mode_sh != 2'h2) |-> phase_a_driver == phase_b_driver;
	endproperty
	a_in_phase: assert property (p_in_phase) else $error("drivers not in phase");
	property p_stuck_off;
		$rose(drive_stuck_fault) |-> ##[0:1] !drv_on;
	endproperty
	a_stuck_off: assert property (p_stuck_off) else $error("drivers left on after stuck");
	property p_stuck_bound;
		(mode_sh != 2'h2 && tmo_sh != 3'h7) |-> int'(idle_cnt) <= lim + 6;
	endproperty
	a_stuck_bound: assert property (p_stuck_bound) else $error("stuck timeout late");
	property p_stuck_cause;
		$rose(drive_stuck_fault) |-> int'($past(idle_cnt)) + 8 >= lim;
	endproperty
	a_stuck_cause: assert property (p_stuck_cause) else $error("stuck flag too early");
	property p_pulse_clear;
		$fell(pulse_count_fault) |-> $past(ctrl_wr && pwdata[16]) or ##[0:4] drv_on;
	endproperty
	a_pulse_clear: assert property (p_pulse_clear) else $error("pulse fault cleared");
	property p_stuck_clear;
		$fell(drive_stuck_fault) |->
			$past(ctrl_wr && (pwdata[16] || pwdata[10:8] == 3'h7)) or ##[0:4] drv_on;
	endproperty
	a_stuck_clear: assert property (p_stuck_clear) else $error("stuck fault cleared");
	property p_no_count_mode2;
		$rose(pulse_count_fault) |-> mode_sh != 2'h2;
	endproperty
	a_no_count_mode2: assert property (p_no_count_mode2) else $error("pulse fault in mode 2");
	c_stuck: cover property ($rose(drive_stuck_fault));
	c_pulse: cover property ($rose(pulse_count_fault));
	c_coil: cover property (coil_sh && phase_a_driver);
endmodule : burst_fault_monitor_props

// *** tb/mcu_pin_driver.sv ***
// Controller model driving the two burst control pins.
// Assumes the bench steers run, half period and the first pin on ref_clk.
`timescale 1ns/10ps
module mcu_pin_driver (
	input wire logic ref_clk,
	input wire logic run,
	input wire logic first_lvl,
	input wire logic [7:0] half,
	output logic ctrl_pin_first,
	output logic ctrl_pin_second
);
	logic [7:0] cnt = 8'h00;
	logic second_reg = 1'b1;
	assign ctrl_pin_first = first_lvl;
	assign ctrl_pin_second = second_reg;
	// Second pin rests high when stopped, as with a pull-up
	always @(posedge ref_clk) begin
		if (!run) begin
			cnt <= 8'h00;
			second_reg <= 1'b1;
		end else if (cnt == half) begin
			cnt <= 8'h00;
			second_reg <= !second_reg;
		end else begin
			cnt <= cnt + 8'h01;
		end
	end
endmodule : mcu_pin_driver

// *** tb/burst_fault_monitor_tb_top.sv ***
// Self-checking bench for the burst fault monitor over APB and the pins.
// Assumes the design files and the constants header are compiled first.
`timescale 1ns/10ps
`include "burst_fault_consts.svh"
module burst_fault_monitor_tb_top;
	logic ref_clk, nrst, psel, penable, pwrite, err, run, first_lvl;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic pready, pslverr, pin_f, pin_s, pha, phb, pcf, dsf, irq;
	logic [2:0] ilim;
	int num_errors = 0;
	int checks = 0;
	int cyc = 0;
	burst_fault_monitor i_dut (.ref_clk(ref_clk), .nrst(nrst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .ctrl_pin_first(pin_f),
		.ctrl_pin_second(pin_s), .phase_a_driver(pha), .phase_b_driver(phb),
		.drive_current_limit_sel(ilim), .pulse_count_fault(pcf),
		.drive_stuck_fault(dsf), .irq(irq));
	mcu_pin_driver i_mcu (.ref_clk(ref_clk), .run(run), .first_lvl(first_lvl),
		.half(8'h04), .ctrl_pin_first(pin_f), .ctrl_pin_second(pin_s));
	// ********
	// Tasks
	// ********
	task automatic complete_run;
		$display("checks %0d mismatches %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : complete_run
	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk
	// Idle cycle after each transfer keeps psel from being driven twice in one step
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		@(posedge ref_clk);
		while (pready !== 1'b1) @(posedge ref_clk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge ref_clk);
	endtask : apb
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string name);
		apb(1'b0, a, 32'h0);
		chk(name, rd, exp);
	endtask : rd_chk
	task automatic clk(input int n);
		repeat (n) @(posedge ref_clk);
	endtask : clk
	// ********
	// Sequence
	// ********
	initial begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			num_errors++;
			complete_run();
		end
	end
	initial begin
		{nrst, psel, penable, pwrite, run, paddr, pwdata} = '0;
		first_lvl = 1'b1;
		clk(3);
		nrst <= 1'b1;
		clk(1);
		rd_chk(`OFS_CTRL, 32'h300, "ctrl");
		rd_chk(`OFS_PULSE_CFG, 32'h0a, "pulse_cfg");
		rd_chk(8'h20, 32'h0, "unmapped");
		chk("pslverr", err, 1'b1);
		$display("test reset done");
		apb(1'b1, `OFS_PULSE_CFG, 32'h4);
		apb(1'b1, `OFS_CTRL, 32'h1350);
		run <= 1'b1;
		clk(70);
		run <= 1'b0;
		rd_chk(`OFS_STATUS, 32'h10400, "status");
		chk("ilim", ilim, 3'h5);
		$display("test full burst done");
		apb(1'b1, `OFS_CTRL, 32'h1350);
		run <= 1'b1;
		clk(30);
		apb(1'b1, `OFS_CTRL, 32'h2350);
		run <= 1'b0;
		chk("spi end fault", pcf, 1'b1);
		chk("irq masked", irq, 1'b0);
		apb(1'b1, `OFS_IRQ_MASK, 32'h7);
		chk("irq", irq, 1'b1);
		rd_chk(`OFS_IRQ_STAT, 32'h5, "irq_stat");
		chk("irq cleared", irq, 1'b0);
		$display("test early end done");
		apb(1'b1, `OFS_PULSE_CFG, 32'h0a);
		apb(1'b1, `OFS_CTRL, 32'h1350);
		run <= 1'b1;
		clk(20);
		run <= 1'b0;
		clk(200);
		chk("stuck", dsf, 1'b1);
		chk("stuck count", pcf, 1'b1);
		chk("drivers", {pha, phb}, 2'b00);
		apb(1'b1, `OFS_CTRL, 32'h0750);
		chk("stuck off", dsf, 1'b0);
		chk("count kept", pcf, 1'b1);
		apb(1'b1, `OFS_CTRL, 32'h10350);
		chk("standby", pcf, 1'b0);
		apb(1'b1, `OFS_CTRL, 32'h1350);
		apb(1'b1, `OFS_CTRL, 32'h2350);
		chk("not started", pcf, 1'b0);
		$display("test stuck done");
		apb(1'b1, `OFS_PULSE_CFG, 32'h3);
		apb(1'b1, `OFS_CTRL, 32'h0357);
		run <= 1'b1;
		clk(50);
		repeat (4) begin
			clk(7);
			chk("blank", {pha, phb}, 2'b00);
		end
		rd_chk(`OFS_STATUS, 32'h80300, "blank state");
		run <= 1'b0;
		chk("mode3 count", pcf, 1'b0);
		// Blank-out must run out before the next mode can see pin edges
		clk(150);
		rd_chk(`OFS_STATUS, 32'h10300, "blank over");
		$display("test single coil done");
		apb(1'b1, `OFS_CTRL, 32'h0351);
		first_lvl <= 1'b0;
		run <= 1'b1;
		clk(20);
		first_lvl <= 1'b1;
		clk(6);
		run <= 1'b0;
		chk("pin end fault", pcf, 1'b1);
		apb(1'b1, `OFS_CTRL, 32'h0352);
		first_lvl <= 1'b0;
		clk(6);
		first_lvl <= 1'b1;
		clk(6);
		first_lvl <= 1'b0;
		clk(6);
		chk("mode2 drive", {pha, phb}, 2'b10);
		// Pins held still: the stuck check ends the burst with no count fault
		clk(170);
		chk("mode2 stuck", dsf, 1'b1);
		chk("mode2 count", pcf, 1'b0);
		first_lvl <= 1'b1;
		$display("test pin modes done");
		complete_run();
	end
endmodule : burst_fault_monitor_tb_top
bind burst_fault_monitor burst_fault_monitor_props i_props (.ref_clk(ref_clk), .nrst(nrst),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.ctrl_pin_second(ctrl_pin_second), .phase_a_driver(phase_a_driver),
	.phase_b_driver(phase_b_driver), .drive_current_limit_sel(drive_current_limit_sel),
	.pulse_count_fault(pulse_count_fault), .drive_stuck_fault(drive_stuck_fault));
